// >>> rtl/csfr_status_regs.sv
// Purpose: Status, fault, input-status/mask and reset/identity registers behind an I2C slave.
// Assumes: One 10 MHz clock; all condition inputs and the bus pins are asynchronous.
// Notes: The SDA pin is open drain; sda_oe_o high pulls the line low.
`include "csfr_defines.svh"

// How it works
// - Detection variant source codes incl. boost 111
// - Select-pin variant: 001, 010, boost 111
// - Current limit not reported in source type
// - Charge phase: off, pre, fast, done
// - Power good bit follows input quality
// - Thermal regulation bit follows regulation
// - Minimum system regulation bit follows condition
// - Watchdog fault bit shows timer expiry
// - Boost fault on any boost-stopping condition
// - Charge error: input, thermal, safety timer
// - Battery error shows battery overvoltage
// - Temperature zone codes from thermistor
// - Temperature zone live, never latched
// - Input attached bit shows good supply
// - Input voltage/current regulation status bits
// - Constant-voltage bit gated by direct output
// - Top-off bit shows timer counting
// - Adapter overvoltage bit follows input overvoltage
// - Voltage regulation interrupt mask, reset 0
// - Current regulation interrupt mask, reset 0
// - Register reset restores defaults, restarts timer
// - Register reset bit clears itself
module csfr_status_regs #(
   parameter bit HAS_DATA_LINE_DET = 1'b1,
   parameter logic [6:0] DEV_ADDR = 7'h6b,
   // Identity values are arbitrary.
   parameter logic [3:0] PART_NUMBER = 4'h3,
   parameter logic MAKER_MARKER = 1'b1,
   parameter logic [1:0] SILICON_REVISION = 2'h1
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic [2:0] det_code_i,
   input wire logic src_sel_hi_i,
   input wire logic boost_on_i,
   input wire logic chg_enabled_i,
   input wire logic bat_below_pre_i,
   input wire logic chg_done_i,
   input wire logic power_good_i,
   input wire logic thermal_reg_i,
   input wire logic sys_min_reg_i,
   input wire logic wdog_expired_i,
   input wire logic boost_overload_i,
   input wire logic boost_bat_low_i,
   input wire logic input_ovp_i,
   input wire logic input_low_i,
   input wire logic thermal_shutdown_i,
   input wire logic safety_expired_i,
   input wire logic bat_ovp_i,
   input wire logic ntc_warm_i,
   input wire logic ntc_cool_i,
   input wire logic ntc_cold_i,
   input wire logic ntc_hot_i,
   input wire logic buck_mode_i,
   input wire logic input_attached_i,
   input wire logic input_volt_reg_i,
   input wire logic input_curr_reg_i,
   input wire logic direct_charge_output_i,
   input wire logic cv_near_i,
   input wire logic topoff_counting_i,
   output logic sda_o_o,
   output logic sda_oe_o,
   output logic int_pulse_o,
   output logic reg_reset_o
);

   localparam int NSYNC = 32;

   // =====================================================================
   // Input synchronisers
   logic [NSYNC-1:0] sync1_r;
   logic [NSYNC-1:0] sync2_r;
   logic scl_s, sda_s, src_sel_s, boost_s, chg_en_s, bat_pre_s, chg_done_s, pg_s, therm_s, sysmin_s;
   logic wdog_s, bovl_s, bbat_s, iovp_s, ilow_s, tsd_s, sft_s, bovp_s, warm_s, cool_s, cold_s, hot_s;
   logic buck_s, attach_s, vreg_s, ireg_s, direct_charge_output_s, cvn_s, topoff_s;
   logic [2:0] det_s;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {scl_i, sda_i, det_code_i, src_sel_hi_i, boost_on_i, chg_enabled_i, bat_below_pre_i,
                     chg_done_i, power_good_i, thermal_reg_i, sys_min_reg_i, wdog_expired_i, boost_overload_i,
                     boost_bat_low_i, input_ovp_i, input_low_i, thermal_shutdown_i, safety_expired_i, bat_ovp_i,
                     ntc_warm_i, ntc_cool_i, ntc_cold_i, ntc_hot_i, buck_mode_i, input_attached_i,
                     input_volt_reg_i, input_curr_reg_i, direct_charge_output_i, cv_near_i, topoff_counting_i};
         sync2_r <= sync1_r;
      end
   end

   assign {scl_s, sda_s, det_s, src_sel_s, boost_s, chg_en_s, bat_pre_s, chg_done_s, pg_s, therm_s, sysmin_s,
           wdog_s, bovl_s, bbat_s, iovp_s, ilow_s, tsd_s, sft_s, bovp_s, warm_s, cool_s, cold_s, hot_s,
           buck_s, attach_s, vreg_s, ireg_s, direct_charge_output_s, cvn_s, topoff_s} = sync2_r;

   // =====================================================================
   // Live status registers
   logic [7:0] chg_status_r, chg_status_nxt;
   logic [7:0] fault_status_r, fault_status_nxt;
   logic [5:0] input_status_r, input_status_nxt;
   logic [2:0] src_nxt;
   logic [1:0] phase_nxt;
   logic [1:0] cerr_nxt;
   logic [2:0] zone_nxt;

   always_comb begin
      src_nxt = `CSFR_SRC_NONE;
      if (boost_s) begin
         src_nxt = `CSFR_SRC_BOOST;
      end else if (!attach_s) begin
         src_nxt = `CSFR_SRC_NONE;
      end else if (HAS_DATA_LINE_DET) begin
         if (det_s == `CSFR_SRC_BAD || det_s == `CSFR_SRC_BOOST) begin
            src_nxt = `CSFR_SRC_UNKNOWN;
         end else begin
            src_nxt = det_s;
         end
      end else begin
         src_nxt = src_sel_s ? `CSFR_SRC_HOSTPORT : `CSFR_SRC_ADAPTER;
      end
      // no current limit here
      // The detected limit goes to the input current setting register, so only the type is coded.
      // charge phase coding
      if (!chg_en_s) begin
         phase_nxt = `CSFR_PH_OFF;
      end else if (chg_done_s) begin
         phase_nxt = `CSFR_PH_DONE;
      end else if (bat_pre_s) begin
         phase_nxt = `CSFR_PH_PRE;
      end else begin
         phase_nxt = `CSFR_PH_FAST;
      end
      if (sft_s) begin
         cerr_nxt = `CSFR_CE_TIMER;
      end else if (tsd_s) begin
         cerr_nxt = `CSFR_CE_THERM;
      end else if (iovp_s || ilow_s) begin
         cerr_nxt = `CSFR_CE_INPUT;
      end else begin
         cerr_nxt = `CSFR_CE_NONE;
      end
      if (hot_s) begin
         zone_nxt = `CSFR_TZ_HOT;
      end else if (cold_s) begin
         zone_nxt = `CSFR_TZ_COLD;
      end else if (warm_s && buck_s) begin
         zone_nxt = `CSFR_TZ_WARM;
      end else if (cool_s && buck_s) begin
         zone_nxt = `CSFR_TZ_COOL;
      end else begin
         zone_nxt = `CSFR_TZ_NORMAL;
      end
      chg_status_nxt = {src_nxt, phase_nxt, pg_s, therm_s, sysmin_s};
      fault_status_nxt = {wdog_s, bovl_s | iovp_s | bbat_s, cerr_nxt, bovp_s, zone_nxt};
      input_status_nxt = {attach_s, vreg_s, ireg_s, direct_charge_output_s & cvn_s, topoff_s, iovp_s};
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         chg_status_r <= '0;
         fault_status_r <= '0;
         input_status_r <= '0;
      end else begin
         chg_status_r <= chg_status_nxt;
         fault_status_r <= fault_status_nxt;
         input_status_r <= input_status_nxt;
      end
   end

   // =====================================================================
   // Masks, register reset and interrupt pulse
   logic [1:0] mask_r, mask_nxt;
   logic reg_rst_r, reg_rst_nxt;
   logic reg_reset_r, reg_reset_nxt;
   logic int_r, int_nxt;
   logic wr_stb_r;
   logic [7:0] wr_addr_r;
   logic [7:0] wr_data_r;
   logic v_entry, i_entry;

   assign v_entry = vreg_s && !input_status_r[`CSFR_BIT_VREG - 2];
   assign i_entry = ireg_s && !input_status_r[`CSFR_BIT_IREG - 2];

   always_comb begin
      mask_nxt = mask_r;
      reg_rst_nxt = reg_rst_r;
      reg_reset_nxt = 1'b0;
      if (reg_rst_r) begin
         mask_nxt = `CSFR_MASK_RST;
         reg_reset_nxt = 1'b1;
         reg_rst_nxt = 1'b0;
      end else if (wr_stb_r) begin
         if (wr_addr_r == `CSFR_ADDR_INPUT_STATUS) begin
            mask_nxt = wr_data_r[`CSFR_BIT_VMASK:`CSFR_BIT_IMASK];
         end
         if (wr_addr_r == `CSFR_ADDR_RESET_ID && wr_data_r[`CSFR_BIT_REG_RST]) begin
            reg_rst_nxt = 1'b1;
         end
      end
      int_nxt = (v_entry && !mask_r[`CSFR_BIT_VMASK]) || (i_entry && !mask_r[`CSFR_BIT_IMASK]);
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mask_r <= `CSFR_MASK_RST;
         reg_rst_r <= 1'b0;
         reg_reset_r <= 1'b0;
         int_r <= 1'b0;
      end else begin
         mask_r <= mask_nxt;
         reg_rst_r <= reg_rst_nxt;
         reg_reset_r <= reg_reset_nxt;
         int_r <= int_nxt;
      end
   end

   assign int_pulse_o = int_r;
   assign reg_reset_o = reg_reset_r;

   // =====================================================================
   // Register read mux
   function automatic logic [7:0] read_reg(input logic [7:0] addr, input logic [7:0] st08,
                                           input logic [7:0] st09, input logic [5:0] st0a,
                                           input logic [1:0] masks, input logic rst);
      logic [7:0] val;
      val = `CSFR_READ_NONE;
      case (addr)
         `CSFR_ADDR_CHG_STATUS: val = st08;
         `CSFR_ADDR_FAULT_STATUS: val = st09;
         `CSFR_ADDR_INPUT_STATUS: val = {st0a, masks};
         `CSFR_ADDR_RESET_ID: val = {rst, PART_NUMBER, MAKER_MARKER, SILICON_REVISION};
         default: val = `CSFR_READ_NONE;
      endcase
      return val;
   endfunction

   // =====================================================================
   // I2C slave
   logic scl_d_r, sda_d_r;
   logic scl_rise, scl_fall, bus_start, bus_stop;
   csfr_pkg::csfr_i2c_state_t st_r, st_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [7:0] tx_r, tx_nxt;
   logic [7:0] ptr_r, ptr_nxt;
   logic rw_r, rw_nxt;
   logic oe_r, oe_nxt;
   logic wr_stb_nxt;
   logic [7:0] wr_addr_nxt, wr_data_nxt;
   logic [7:0] rd_next;

   assign scl_rise = scl_s && !scl_d_r;
   assign scl_fall = !scl_s && scl_d_r;
   assign bus_start = scl_s && scl_d_r && sda_d_r && !sda_s;
   assign bus_stop = scl_s && scl_d_r && !sda_d_r && sda_s;
   assign rd_next = read_reg(ptr_r + 8'h01, chg_status_r, fault_status_r, input_status_r, mask_r, reg_rst_r);

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      tx_nxt = tx_r;
      ptr_nxt = ptr_r;
      rw_nxt = rw_r;
      oe_nxt = oe_r;
      wr_stb_nxt = 1'b0;
      wr_addr_nxt = wr_addr_r;
      wr_data_nxt = wr_data_r;
      if (bus_start) begin
         st_nxt = csfr_pkg::CSFR_ADDR;
         cnt_nxt = '0;
         oe_nxt = 1'b0;
      end else if (bus_stop) begin
         st_nxt = csfr_pkg::CSFR_IDLE;
         oe_nxt = 1'b0;
      end else if (scl_rise && st_r != csfr_pkg::CSFR_IDLE) begin
         sh_nxt = {sh_r[6:0], sda_s};
         cnt_nxt = cnt_r + 4'h1;
      end else if (scl_fall) begin
         case (st_r)
            csfr_pkg::CSFR_ADDR: begin
               if (cnt_r == `CSFR_BYTE_LEN) begin
                  if (sh_r[7:1] == DEV_ADDR) begin
                     st_nxt = csfr_pkg::CSFR_ACK_ADDR;
                     rw_nxt = sh_r[0];
                     oe_nxt = 1'b1;
                  end else begin
                     st_nxt = csfr_pkg::CSFR_IDLE;
                  end
               end
            end
            csfr_pkg::CSFR_REG: begin
               if (cnt_r == `CSFR_BYTE_LEN) begin
                  st_nxt = csfr_pkg::CSFR_ACK_REG;
                  ptr_nxt = sh_r;
                  oe_nxt = 1'b1;
               end
            end
            csfr_pkg::CSFR_WDATA: begin
               if (cnt_r == `CSFR_BYTE_LEN) begin
                  st_nxt = csfr_pkg::CSFR_ACK_W;
                  wr_stb_nxt = 1'b1;
                  wr_addr_nxt = ptr_r;
                  wr_data_nxt = sh_r;
                  oe_nxt = 1'b1;
               end
            end
            csfr_pkg::CSFR_ACK_ADDR: begin
               cnt_nxt = '0;
               if (rw_r) begin
                  // A read snapshots the whole byte so its fields are coherent.
                  tx_nxt = read_reg(ptr_r, chg_status_r, fault_status_r, input_status_r, mask_r, reg_rst_r);
                  oe_nxt = !tx_nxt[7];
                  st_nxt = csfr_pkg::CSFR_RDATA;
               end else begin
                  oe_nxt = 1'b0;
                  st_nxt = csfr_pkg::CSFR_REG;
               end
            end
            csfr_pkg::CSFR_ACK_REG, csfr_pkg::CSFR_ACK_W: begin
               if (st_r == csfr_pkg::CSFR_ACK_W) begin
                  ptr_nxt = ptr_r + 8'h01;
               end
               cnt_nxt = '0;
               oe_nxt = 1'b0;
               st_nxt = csfr_pkg::CSFR_WDATA;
            end
            csfr_pkg::CSFR_RDATA: begin
               // The rising edge already counts each bit sent, so the byte ends after the eighth rise.
               if (cnt_r == `CSFR_BYTE_LEN) begin
                  oe_nxt = 1'b0;
                  st_nxt = csfr_pkg::CSFR_RACK;
               end else begin
                  tx_nxt = {tx_r[6:0], 1'b0};
                  oe_nxt = !tx_r[6];
               end
            end
            csfr_pkg::CSFR_RACK: begin
               if (!sh_r[0]) begin
                  ptr_nxt = ptr_r + 8'h01;
                  tx_nxt = rd_next;
                  oe_nxt = !rd_next[7];
                  cnt_nxt = '0;
                  st_nxt = csfr_pkg::CSFR_RDATA;
               end else begin
                  st_nxt = csfr_pkg::CSFR_IDLE;
               end
            end
            default: begin
               st_nxt = st_r;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         st_r <= csfr_pkg::CSFR_IDLE;
         cnt_r <= '0;
         sh_r <= '0;
         tx_r <= '0;
         ptr_r <= '0;
         rw_r <= 1'b0;
         oe_r <= 1'b0;
         wr_stb_r <= 1'b0;
         wr_addr_r <= '0;
         wr_data_r <= '0;
         sda_o_o <= 1'b0;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         tx_r <= tx_nxt;
         ptr_r <= ptr_nxt;
         rw_r <= rw_nxt;
         oe_r <= oe_nxt;
         wr_stb_r <= wr_stb_nxt;
         wr_addr_r <= wr_addr_nxt;
         wr_data_r <= wr_data_nxt;
         sda_o_o <= 1'b0;
      end
   end

   assign sda_oe_o = oe_r;

   // =====================================================================
   // Assertions
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rstn_i);

   sequence s_rst_write;
      wr_stb_r && wr_addr_r == `CSFR_ADDR_RESET_ID && wr_data_r[`CSFR_BIT_REG_RST] && !reg_rst_r;
   endsequence
   sequence s_rst_done;
      reg_rst_r ##1 (!reg_rst_r && reg_reset_o && mask_r == `CSFR_MASK_RST);
   endsequence

   a_rst_self_clear: assert property (s_rst_write |=> s_rst_done)
      else $error("register reset bit did not clear after one cycle");
   a_rst_mask_default: assert property (reg_reset_o |-> mask_r == `CSFR_MASK_RST && !reg_rst_r)
      else $error("masks not at default after register reset");
   a_src_boost_code: assert property (boost_s |=> chg_status_r[7:5] == `CSFR_SRC_BOOST)
      else $error("boost not reported as source type");
   a_phase_off_code: assert property (!chg_en_s |=> chg_status_r[4:3] == `CSFR_PH_OFF)
      else $error("disabled charge not reported as phase zero");
   a_fault_timer_prio: assert property (sft_s |=> fault_status_r[5:4] == `CSFR_CE_TIMER)
      else $error("safety timer expiry not reported");
   a_zone_live: assert property (!hot_s && !cold_s && !warm_s && !cool_s
                                 |=> fault_status_r[2:0] == `CSFR_TZ_NORMAL)
      else $error("temperature zone latched after condition ended");
   a_vint_masked: assert property (v_entry && mask_r[`CSFR_BIT_VMASK]
                                   && !(i_entry && !mask_r[`CSFR_BIT_IMASK]) |=> !int_pulse_o)
      else $error("masked voltage regulation produced a pulse");
   a_int_fire_once: assert property (v_entry && !mask_r[`CSFR_BIT_VMASK]
                                     |=> int_pulse_o ##1 (!int_pulse_o || $past(i_entry)))
      else $error("regulation entry pulse missing or too long");
   a_cv_gated: assert property (!direct_charge_output_s |=> !input_status_r[`CSFR_BIT_CV - 2])
      else $error("constant voltage bit set without direct charge output");

endmodule

// >>> rtl/csfr_defines.svh
// Purpose: Named offsets, field positions, codes and reset values of the charger status block.
// Assumes: Included by bare name wherever a constant is needed.
// Notes: Definitions only.
`ifndef CSFR_DEFINES_SVH
`define CSFR_DEFINES_SVH

// =====================================================================
// Register offsets
`define CSFR_ADDR_CHG_STATUS 8'h08
`define CSFR_ADDR_FAULT_STATUS 8'h09
`define CSFR_ADDR_INPUT_STATUS 8'h0a
`define CSFR_ADDR_RESET_ID 8'h0b

// =====================================================================
// Source type codes
`define CSFR_SRC_NONE 3'h0
`define CSFR_SRC_SDP 3'h1
`define CSFR_SRC_CDP 3'h2
`define CSFR_SRC_DCP 3'h3
`define CSFR_SRC_BAD 3'h4
`define CSFR_SRC_UNKNOWN 3'h5
`define CSFR_SRC_NONSTD 3'h6
`define CSFR_SRC_BOOST 3'h7
`define CSFR_SRC_HOSTPORT 3'h1
`define CSFR_SRC_ADAPTER 3'h2

// =====================================================================
// Charge phase, charge error and temperature zone codes
`define CSFR_PH_OFF 2'h0
`define CSFR_PH_PRE 2'h1
`define CSFR_PH_FAST 2'h2
`define CSFR_PH_DONE 2'h3
`define CSFR_CE_NONE 2'h0
`define CSFR_CE_INPUT 2'h1
`define CSFR_CE_THERM 2'h2
`define CSFR_CE_TIMER 2'h3
`define CSFR_TZ_NORMAL 3'h0
`define CSFR_TZ_WARM 3'h2
`define CSFR_TZ_COOL 3'h3
`define CSFR_TZ_COLD 3'h5
`define CSFR_TZ_HOT 3'h6

// =====================================================================
// Field positions and reset values
`define CSFR_BIT_REG_RST 7
`define CSFR_BIT_VMASK 1
`define CSFR_BIT_IMASK 0
`define CSFR_BIT_VREG 6
`define CSFR_BIT_IREG 5
`define CSFR_BIT_CV 4
`define CSFR_MASK_RST 2'h0
`define CSFR_BYTE_LEN 4'h8
`define CSFR_LAST_BIT 4'h7
`define CSFR_READ_NONE 8'h00

`endif

// >>> rtl/csfr_pkg.sv
// Purpose: Types shared by the charger status block.
// Assumes: Constants live in csfr_defines.svh.
// Notes: Nothing here is imported; users write csfr_pkg::name.
package csfr_pkg;

   // =====================================================================
   // Serial slave states
   typedef enum logic [3:0] {
      CSFR_IDLE,
      CSFR_ADDR,
      CSFR_ACK_ADDR,
      CSFR_REG,
      CSFR_ACK_REG,
      CSFR_WDATA,
      CSFR_ACK_W,
      CSFR_RDATA,
      CSFR_RACK
   } csfr_i2c_state_t;

endpackage

// >>> sim/csfr_host.sv
// Purpose: Host model that reads and writes the status registers over the serial bus.
// Assumes: SDA is open drain with a pull-up; the device pulls it low through sda_oe_i.
// Notes: Each SCL phase lasts at least five system clocks.
module csfr_host (
   input wire logic clk_i,
   input wire logic sda_oe_i,
   output logic scl_o,
   output logic sda_o
);
   logic drv_low;

   initial begin
      scl_o = 1'b1;
      drv_low = 1'b0;
   end
   assign sda_o = !drv_low && !sda_oe_i;

   // ====================
   // Bus phases
   task automatic ph;
      repeat (5) @(negedge clk_i);
   endtask

   task automatic start;
      drv_low = 1'b0;
      ph();
      scl_o = 1'b1;
      ph();
      drv_low = 1'b1;
      ph();
      scl_o = 1'b0;
      ph();
   endtask

   task automatic stop;
      drv_low = 1'b1;
      ph();
      scl_o = 1'b1;
      ph();
      drv_low = 1'b0;
      ph();
   endtask

   // Nine bits, MSB first; a one releases the line so the device may answer.
   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         drv_low = !d[i];
         ph();
         scl_o = 1'b1;
         ph();
         q[i] = sda_o;
         scl_o = 1'b0;
         ph();
      end
   endtask

   task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic nak);
      logic [8:0] q0, q1, q2;
      start();
      xfer({dev, 2'b01}, q0);
      xfer({a, 1'b1}, q1);
      xfer({d, 1'b1}, q2);
      stop();
      nak = q0[0] | q1[0] | q2[0];
   endtask

   task automatic rd(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d);
      logic [8:0] q;
      start();
      xfer({dev, 2'b01}, q);
      xfer({a, 1'b1}, q);
      start();
      xfer({dev, 2'b11}, q);
      xfer(9'h1ff, q);
      stop();
      d = q[8:1];
   endtask
endmodule

// >>> sim/csfr_tb.sv
// Purpose: Self-checking bench for the charger status register block.
// Assumes: Condition inputs change at the falling clock edge.
// Notes: Identity parameter values are arbitrary.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [3:0] PN = 4'h9;
   localparam logic MK = 1'b0;
   localparam logic [1:0] RV = 2'h2;
   localparam logic [7:0] ID = {1'b0, PN, MK, RV};
   logic clk, rstn, scl, sda, sda_oe, int_pulse, reg_reset;
   logic sda_oe2, sda_lo;
   logic [2:0] det;
   logic [26:0] c;
   int n_fail = 0;
   int checks_done = 0;
   int n_int = 0;
   int n_rst = 0;

   csfr_status_regs #(.HAS_DATA_LINE_DET(1'b1), .DEV_ADDR(7'h6b), .PART_NUMBER(PN), .MAKER_MARKER(MK),
      .SILICON_REVISION(RV)) i_dut (
      .clk_sys_i(clk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda), .det_code_i(det), .src_sel_hi_i(c[0]),
      .boost_on_i(c[1]), .chg_enabled_i(c[2]), .bat_below_pre_i(c[3]), .chg_done_i(c[4]),
      .power_good_i(c[5]), .thermal_reg_i(c[6]), .sys_min_reg_i(c[7]), .wdog_expired_i(c[8]),
      .boost_overload_i(c[9]), .boost_bat_low_i(c[10]), .input_ovp_i(c[11]), .input_low_i(c[12]),
      .thermal_shutdown_i(c[13]), .safety_expired_i(c[14]), .bat_ovp_i(c[15]), .ntc_warm_i(c[16]),
      .ntc_cool_i(c[17]), .ntc_cold_i(c[18]), .ntc_hot_i(c[19]), .buck_mode_i(c[20]),
      .input_attached_i(c[21]), .input_volt_reg_i(c[22]), .input_curr_reg_i(c[23]),
      .direct_charge_output_i(c[24]), .cv_near_i(c[25]), .topoff_counting_i(c[26]),
      .sda_o_o(sda_lo), .sda_oe_o(sda_oe), .int_pulse_o(int_pulse), .reg_reset_o(reg_reset));

   // Select-pin variant on the same bus at its own address.
   csfr_status_regs #(.HAS_DATA_LINE_DET(1'b0), .DEV_ADDR(7'h6a)) i_dut_sel (
      .clk_sys_i(clk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda), .det_code_i(det), .src_sel_hi_i(c[0]),
      .boost_on_i(c[1]), .chg_enabled_i(c[2]), .bat_below_pre_i(c[3]), .chg_done_i(c[4]),
      .power_good_i(c[5]), .thermal_reg_i(c[6]), .sys_min_reg_i(c[7]), .wdog_expired_i(c[8]),
      .boost_overload_i(c[9]), .boost_bat_low_i(c[10]), .input_ovp_i(c[11]), .input_low_i(c[12]),
      .thermal_shutdown_i(c[13]), .safety_expired_i(c[14]), .bat_ovp_i(c[15]), .ntc_warm_i(c[16]),
      .ntc_cool_i(c[17]), .ntc_cold_i(c[18]), .ntc_hot_i(c[19]), .buck_mode_i(c[20]),
      .input_attached_i(c[21]), .input_volt_reg_i(c[22]), .input_curr_reg_i(c[23]),
      .direct_charge_output_i(c[24]), .cv_near_i(c[25]), .topoff_counting_i(c[26]),
      .sda_o_o(), .sda_oe_o(sda_oe2), .int_pulse_o(), .reg_reset_o());

   csfr_host i_host (.clk_i(clk), .sda_oe_i(sda_oe | sda_oe2), .scl_o(scl), .sda_o(sda));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      if (int_pulse === 1'b1) n_int++;
      if (reg_reset === 1'b1) n_rst++;
   end

   // ====================
   // Shared checks
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk(input logic [26:0] cv, input logic [2:0] d, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      @(negedge clk);
      c = cv;
      det = d;
      repeat (5) @(negedge clk);
      i_host.rd(7'h6b, a, q);
      cmp(q, exp);
   endtask

   // ====================
   // Scenarios
   task automatic t_bus;
      logic k;
      chk(27'h0, 3'h0, 8'h0a, 8'h00);
      cmp({7'h0, sda_lo}, 8'h00);
      chk(27'h0, 3'h0, 8'h0b, ID);
      i_host.wr(7'h35, 8'h0a, 8'h03, k);
      cmp({7'h0, k}, 8'h01);
      chk(27'h0, 3'h0, 8'h0a, 8'h00);
      i_host.wr(7'h6b, 8'h08, 8'hff, k);
      cmp({7'h0, k}, 8'h00);
      chk(27'h0, 3'h0, 8'h08, 8'h00);
      chk(27'h0, 3'h0, 8'h0c, 8'h00);
   endtask

   task automatic t_src;
      for (int d = 0; d < 8; d++) begin
         chk(27'h200000, d[2:0], 8'h08, {(d == 4 || d == 7) ? 3'h5 : d[2:0], 5'h00});
      end
      chk(27'h2, 3'h3, 8'h08, 8'he0);
   endtask

   task automatic t_sel;
      logic [7:0] q;
      @(negedge clk);
      c = 27'h200001;
      repeat (5) @(negedge clk);
      i_host.rd(7'h6a, 8'h08, q);
      cmp(q, 8'h20);
      c = 27'h200000;
      repeat (5) @(negedge clk);
      i_host.rd(7'h6a, 8'h08, q);
      cmp(q, 8'h40);
      c = 27'h200002;
      repeat (5) @(negedge clk);
      i_host.rd(7'h6a, 8'h08, q);
      cmp(q, 8'he0);
   endtask

   task automatic t_chg;
      chk(27'hc, 3'h0, 8'h08, 8'h08);
      chk(27'h4, 3'h0, 8'h08, 8'h10);
      chk(27'h1c, 3'h0, 8'h08, 8'h18);
      chk(27'h0, 3'h0, 8'h08, 8'h00);
      chk(27'ha0, 3'h0, 8'h08, 8'h05);
      chk(27'h40, 3'h0, 8'h08, 8'h02);
   endtask

   task automatic t_flt;
      chk(27'h100, 3'h0, 8'h09, 8'h80);
      chk(27'h200, 3'h0, 8'h09, 8'h40);
      chk(27'h400, 3'h0, 8'h09, 8'h40);
      chk(27'h800, 3'h0, 8'h09, 8'h50);
      chk(27'h1000, 3'h0, 8'h09, 8'h10);
      chk(27'h2000, 3'h0, 8'h09, 8'h20);
      chk(27'h7000, 3'h0, 8'h09, 8'h30);
      chk(27'h8000, 3'h0, 8'h09, 8'h08);
      chk(27'h110000, 3'h0, 8'h09, 8'h02);
      chk(27'h120000, 3'h0, 8'h09, 8'h03);
      chk(27'h10000, 3'h0, 8'h09, 8'h00);
      chk(27'hc0000, 3'h0, 8'h09, 8'h06);
      chk(27'h40000, 3'h0, 8'h09, 8'h05);
      chk(27'h0, 3'h0, 8'h09, 8'h00);
   endtask

   task automatic t_inp;
      n_int = 0;
      chk(27'h200000, 3'h0, 8'h0a, 8'h80);
      chk(27'h400000, 3'h0, 8'h0a, 8'h40);
      chk(27'h800000, 3'h0, 8'h0a, 8'h20);
      chk(27'h3000000, 3'h0, 8'h0a, 8'h10);
      chk(27'h2000000, 3'h0, 8'h0a, 8'h00);
      chk(27'h4000000, 3'h0, 8'h0a, 8'h08);
      chk(27'h800, 3'h0, 8'h0a, 8'h04);
      cmp(n_int[7:0], 8'h02);
   endtask

   task automatic t_mask;
      logic k;
      i_host.wr(7'h6b, 8'h0a, 8'h02, k);
      n_int = 0;
      chk(27'h400000, 3'h0, 8'h0a, 8'h42);
      chk(27'h800000, 3'h0, 8'h0a, 8'h22);
      cmp(n_int[7:0], 8'h01);
      i_host.wr(7'h6b, 8'h0a, 8'h01, k);
      n_int = 0;
      chk(27'h400000, 3'h0, 8'h0a, 8'h41);
      chk(27'h800000, 3'h0, 8'h0a, 8'h21);
      cmp(n_int[7:0], 8'h01);
   endtask

   task automatic t_rst;
      logic k;
      i_host.wr(7'h6b, 8'h0a, 8'h03, k);
      n_rst = 0;
      i_host.wr(7'h6b, 8'h0b, 8'h7f, k);
      chk(27'h0, 3'h0, 8'h0a, 8'h03);
      chk(27'h0, 3'h0, 8'h0b, ID);
      cmp(n_rst[7:0], 8'h00);
      i_host.wr(7'h6b, 8'h0b, 8'h80, k);
      cmp(n_rst[7:0], 8'h01);
      chk(27'h0, 3'h0, 8'h0a, 8'h00);
      chk(27'h0, 3'h0, 8'h0b, ID);
   endtask

   initial begin
      c = 27'h0;
      det = 3'h0;
      rstn = 1'b0;
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      repeat (5) @(negedge clk);
      t_bus();
      t_src();
      t_sel();
      t_chg();
      t_flt();
      t_inp();
      t_mask();
      t_rst();
      close_out();
   end

   // A hang counts as a mismatch.
   initial begin
      repeat (80000) @(posedge clk);
      n_fail++;
      close_out();
   end
endmodule
